// ### pkg/pbp_params.svh
// Register indices, field positions and reset values of the port B block
`ifndef PBP_PARAMS_SVH
`define PBP_PARAMS_SVH
`define PBP_ADDR_W        18
`define PBP_IDX_DIR       16'hFFD4
`define PBP_IDX_LATCH     16'hFFD6
`define PBP_IDX_CFG       16'hFFD8
`define PBP_DIR_RST       8'h00
`define PBP_LATCH_RST     8'h00
`define PBP_CFG_RST       13'h0000
`define PBP_DIR_READ      32'h000000FF
`define PBP_CFG_CMD       0
`define PBP_CFG_PWM       1
`define PBP_CFG_B_OE      2
`define PBP_CFG_A_OE      3
`define PBP_CFG_INV_A_OE  4
`define PBP_CFG_INV_B_OE  5
`define PBP_CFG_TRIG_EN   6
`define PBP_CFG_A_IO_LSB  8
`define PBP_CFG_B_IO_LSB  12
`endif

// ### pkg/pbp_pkg.sv
// Types shared by the port B block
package pbp_pkg;

  typedef struct packed {
    logic [2:0] ch4_b_io_control;
    logic [2:0] ch4_a_io_control;
    logic       converter_trigger_enable;
    logic       ch4_inv_b_output_enable;
    logic       ch4_inv_a_output_enable;
    logic       ch4_a_output_enable;
    logic       ch4_b_output_enable;
    logic       ch4_pwm_mode;
    logic       combined_mode_select;
  } pbp_cfg_s;

  typedef struct packed {
    logic [7:0]  port_b_direction;
    logic [7:0]  port_b_data_latch;
    pbp_cfg_s    cfg;
    logic [7:0]  sync1;
    logic [7:0]  sync2;
    logic [7:0]  sync3;
    logic [7:0]  pin_level;
    logic [31:0] rdata;
    logic        rdone;
  } pbp_state_s;

endpackage : pbp_pkg

// ### hdl/pbp_top.sv
// Port B: eight two-way pins with shared timer and trigger functions
//
// How it works
// - Direction bit 1 makes a pin output, 0 input, unless timer owns it.
// - Direction register is eight bits, write only, one bit per pin.
// - Reading the direction register returns all ones in the byte.
// - Reset and hardware standby clear the direction register.
// - Software standby keeps direction and output drive unchanged.
// - Data latch is eight bits, readable and writable.
// - Output pin reads return the latch bit.
// - Input pin reads return the pin level.
// - Reset and hardware standby clear the latch; software standby keeps it.
// - Direction at index FFD4, data latch at index FFD6.
// - Pin 3 carries channel 4 compare B when enabled and selected.
// - Pin 3 feeds capture B when combined and pwm are 0, top io bit 1.
// - Pin 4 carries inverted A when its enable and combined mode are 1.
// - Pin 2 feeds capture A when combined and pwm are 0, top io bit 1.
//
// Local design decision: the Avalon-MM slave port.
`include "pbp_params.svh"

module pbp_top
  import pbp_pkg::*;
(
  input  wire logic                   REF_CLK,
  input  wire logic                   RST,
  input  wire logic [`PBP_ADDR_W-1:0] AVS_ADDRESS,
  input  wire logic                   AVS_READ,
  input  wire logic                   AVS_WRITE,
  input  wire logic [31:0]            AVS_WRITEDATA,
  input  wire logic [3:0]             AVS_BYTEENABLE,
  output logic      [31:0]            AVS_READDATA,
  output logic                        AVS_WAITREQUEST,
  input  wire logic                   HW_STANDBY,
  input  wire logic                   SW_STANDBY,
  input  wire logic [7:0]             PB_IN,
  output logic      [7:0]             PB_OUT,
  output logic      [7:0]             PB_OE_N,
  input  wire logic                   CH4_CMP_A,
  input  wire logic                   CH4_CMP_B,
  input  wire logic                   CH4_INV_A,
  input  wire logic                   CH4_INV_B,
  output logic                        CH4_CAP_A,
  output logic                        CH4_CAP_B,
  output logic                        CONVERTER_TRIGGER_IN_N
);

  pbp_state_s st_ff;
  pbp_state_s nxt_st;

  logic [15:0] reg_idx;
  logic        word_ok;
  logic        hit_dir;
  logic        hit_latch;
  logic        hit_cfg;
  logic        wr_take;
  logic [14:0] cfg_bits;
  logic [14:0] cfg_wr;
  logic [7:0]  port_read;
  logic [7:0]  timer_own;
  logic [7:0]  timer_val;
  logic [7:0]  drive;

  logic        cmd;
  logic        pwm;
  logic [2:0]  a_io;
  logic [2:0]  b_io;
  logic        a_cmp_sel;
  logic        b_cmp_sel;
  logic        inv_a_sel;
  logic        inv_b_sel;

  // Address decode: register offsets are word indices
  assign reg_idx   = AVS_ADDRESS[`PBP_ADDR_W-1:2];
  assign word_ok   = (AVS_ADDRESS[1:0] == 2'h0);
  assign hit_dir   = word_ok && (reg_idx == `PBP_IDX_DIR);
  assign hit_latch = word_ok && (reg_idx == `PBP_IDX_LATCH);
  assign hit_cfg   = word_ok && (reg_idx == `PBP_IDX_CFG);

  // Writes finish at once, reads take one wait cycle
  assign AVS_WAITREQUEST = AVS_READ && !st_ff.rdone;
  assign wr_take         = AVS_WRITE && !AVS_READ;
  assign AVS_READDATA    = st_ff.rdata;

  assign cmd  = st_ff.cfg.combined_mode_select;
  assign pwm  = st_ff.cfg.ch4_pwm_mode;
  assign a_io = st_ff.cfg.ch4_a_io_control;
  assign b_io = st_ff.cfg.ch4_b_io_control;

  // Compare B output when enabled: io 001 or 01x, or combined mode
  assign b_cmp_sel = st_ff.cfg.ch4_b_output_enable &&
                     (cmd ||
                      (b_io == 3'h1) ||
                      (b_io[2:1] == 2'h1));

  // Compare A mirrors B, with pwm mode also claiming the pin
  assign a_cmp_sel = st_ff.cfg.ch4_a_output_enable &&
                     (cmd || pwm ||
                      (a_io == 3'h1) ||
                      (a_io[2:1] == 2'h1));

  assign inv_a_sel = st_ff.cfg.ch4_inv_a_output_enable && cmd;
  assign inv_b_sel = st_ff.cfg.ch4_inv_b_output_enable && cmd;

  assign timer_own = {2'h0, inv_b_sel, inv_a_sel,
                      b_cmp_sel, a_cmp_sel, 2'h0};
  assign timer_val = {2'h0, CH4_INV_B, CH4_INV_A,
                      CH4_CMP_B, CH4_CMP_A, 2'h0};

  // Per-pin drive and readback
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      assign drive[gi] = timer_own[gi] ||
                         st_ff.port_b_direction[gi];
      assign PB_OE_N[gi] = !drive[gi];
      assign PB_OUT[gi]  = timer_own[gi] ? timer_val[gi]
                         : st_ff.port_b_data_latch[gi];
      assign port_read[gi] = st_ff.port_b_direction[gi]
                           ? st_ff.port_b_data_latch[gi]
                           : st_ff.pin_level[gi];
    end
  endgenerate

  // Capture inputs see the filtered pin level
  assign CH4_CAP_B = !cmd && !pwm && b_io[2] && st_ff.pin_level[3];
  assign CH4_CAP_A = !cmd && !pwm && a_io[2] && st_ff.pin_level[2];

  // Trigger is active low, so idle high while disabled
  assign CONVERTER_TRIGGER_IN_N =
    st_ff.cfg.converter_trigger_enable ? st_ff.pin_level[7] : 1'b1;

  // Flatten configuration into its register image
  always_comb begin
    cfg_bits = 15'h0000;
    cfg_bits[`PBP_CFG_CMD]      = st_ff.cfg.combined_mode_select;
    cfg_bits[`PBP_CFG_PWM]      = st_ff.cfg.ch4_pwm_mode;
    cfg_bits[`PBP_CFG_B_OE]     = st_ff.cfg.ch4_b_output_enable;
    cfg_bits[`PBP_CFG_A_OE]     = st_ff.cfg.ch4_a_output_enable;
    cfg_bits[`PBP_CFG_INV_A_OE] = st_ff.cfg.ch4_inv_a_output_enable;
    cfg_bits[`PBP_CFG_INV_B_OE] = st_ff.cfg.ch4_inv_b_output_enable;
    cfg_bits[`PBP_CFG_TRIG_EN]  = st_ff.cfg.converter_trigger_enable;
    cfg_bits[`PBP_CFG_A_IO_LSB +: 3] = st_ff.cfg.ch4_a_io_control;
    cfg_bits[`PBP_CFG_B_IO_LSB +: 3] = st_ff.cfg.ch4_b_io_control;
  end

  // Merge a write into the image, byte lane by byte lane
  always_comb begin
    cfg_wr = cfg_bits;
    if (AVS_BYTEENABLE[0]) begin
      cfg_wr[7:0] = AVS_WRITEDATA[7:0];
    end
    if (AVS_BYTEENABLE[1]) begin
      cfg_wr[14:8] = AVS_WRITEDATA[14:8];
    end
  end

  always_comb begin
    nxt_st = st_ff;

    // Three stages; a change counts once the second and third agree
    nxt_st.sync1 = PB_IN;
    nxt_st.sync2 = st_ff.sync1;
    nxt_st.sync3 = st_ff.sync2;
    for (int i = 0; i < 8; i++) begin
      if (st_ff.sync2[i] == st_ff.sync3[i]) begin
        nxt_st.pin_level[i] = st_ff.sync3[i];
      end
    end

    // Read answer is registered, then held until the next read
    nxt_st.rdone = AVS_READ && !st_ff.rdone;
    if (AVS_READ && !st_ff.rdone) begin
      if (hit_dir) begin
        nxt_st.rdata = `PBP_DIR_READ;
      end else if (hit_latch) begin
        nxt_st.rdata = {24'h000000, port_read};
      end else if (hit_cfg) begin
        nxt_st.rdata = {17'h00000, cfg_bits};
      end else begin
        nxt_st.rdata = 32'h00000000;
      end
    end

    if (wr_take) begin
      if (hit_dir && AVS_BYTEENABLE[0]) begin
        nxt_st.port_b_direction = AVS_WRITEDATA[7:0];
      end else if (hit_latch && AVS_BYTEENABLE[0]) begin
        nxt_st.port_b_data_latch = AVS_WRITEDATA[7:0];
      end else if (hit_cfg) begin
        nxt_st.cfg.combined_mode_select    = cfg_wr[`PBP_CFG_CMD];
        nxt_st.cfg.ch4_pwm_mode            = cfg_wr[`PBP_CFG_PWM];
        nxt_st.cfg.ch4_b_output_enable     = cfg_wr[`PBP_CFG_B_OE];
        nxt_st.cfg.ch4_a_output_enable     = cfg_wr[`PBP_CFG_A_OE];
        nxt_st.cfg.ch4_inv_a_output_enable = cfg_wr[`PBP_CFG_INV_A_OE];
        nxt_st.cfg.ch4_inv_b_output_enable = cfg_wr[`PBP_CFG_INV_B_OE];
        nxt_st.cfg.converter_trigger_enable = cfg_wr[`PBP_CFG_TRIG_EN];
        nxt_st.cfg.ch4_a_io_control = cfg_wr[`PBP_CFG_A_IO_LSB +: 3];
        nxt_st.cfg.ch4_b_io_control = cfg_wr[`PBP_CFG_B_IO_LSB +: 3];
      end
    end

    // Software standby needs nothing: the control registers simply hold
    // Hardware standby overrides any write in the same cycle
    if (HW_STANDBY) begin
      nxt_st.port_b_direction  = `PBP_DIR_RST;
      nxt_st.port_b_data_latch = `PBP_LATCH_RST;
      nxt_st.cfg               = `PBP_CFG_RST;
    end
  end

  always_ff @(posedge REF_CLK or posedge RST) begin
    if (RST) begin
      st_ff.port_b_direction  <= `PBP_DIR_RST;
      st_ff.port_b_data_latch <= `PBP_LATCH_RST;
      st_ff.cfg               <= `PBP_CFG_RST;
      st_ff.sync1             <= 8'h00;
      st_ff.sync2             <= 8'h00;
      st_ff.sync3             <= 8'h00;
      st_ff.pin_level         <= 8'h00;
      st_ff.rdata             <= 32'h00000000;
      st_ff.rdone             <= 1'b0;
    end else begin
      st_ff <= nxt_st;
    end
  end

endmodule : pbp_top

// ### bench/pbp_chk.sv
// Concurrent checks on the port B block ports
`include "pbp_params.svh"
module pbp_chk
  import pbp_pkg::*;
(
  input logic                   REF_CLK,
  input logic                   RST,
  input logic [`PBP_ADDR_W-1:0] AVS_ADDRESS,
  input logic                   AVS_READ,
  input logic                   AVS_WRITE,
  input logic [31:0]            AVS_WRITEDATA,
  input logic [3:0]             AVS_BYTEENABLE,
  input logic [31:0]            AVS_READDATA,
  input logic                   AVS_WAITREQUEST,
  input logic                   HW_STANDBY,
  input logic                   SW_STANDBY,
  input logic [7:0]             PB_OUT,
  input logic [7:0]             PB_OE_N,
  input logic                   CH4_CAP_A,
  input logic                   CH4_CAP_B,
  input logic                   CONVERTER_TRIGGER_IN_N
);
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_DIR = {`PBP_IDX_DIR, 2'b00};
  localparam logic [17:0] A_LAT = {`PBP_IDX_LATCH, 2'b00};
  logic wr_ok;
  // Pins 0, 1, 6 and 7 never pass to the timer
  assign wr_ok = AVS_WRITE & !AVS_READ & !HW_STANDBY & AVS_BYTEENABLE[0];
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (RST);
  sequence s_one_wait;
    AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
  endsequence
  chk_read_wait: assert property ($rose(AVS_READ) |-> s_one_wait)
    else $error("read wait is not one cycle");
  chk_write_nowait: assert property (AVS_WRITE && !AVS_READ |->
    !AVS_WAITREQUEST) else $error("write was stalled");
  chk_dir_ones: assert property (AVS_READ && !AVS_WAITREQUEST &&
    AVS_ADDRESS == A_DIR |-> AVS_READDATA == `PBP_DIR_READ)
    else $error("direction read not all ones");
  chk_dir_drive: assert property (wr_ok && AVS_ADDRESS == A_DIR |=>
    (PB_OE_N & 8'hC3) == (~$past(AVS_WRITEDATA[7:0]) & 8'hC3))
    else $error("enable does not follow direction");
  chk_latch_out: assert property (wr_ok && AVS_ADDRESS == A_LAT |=>
    (PB_OUT & 8'hC3) == ($past(AVS_WRITEDATA[7:0]) & 8'hC3))
    else $error("pin value does not follow latch");
  chk_hw_clear: assert property (HW_STANDBY |=> PB_OE_N == 8'hFF &&
    !CH4_CAP_A && !CH4_CAP_B && CONVERTER_TRIGGER_IN_N)
    else $error("hardware standby did not clear");
  chk_sw_hold: assert property (SW_STANDBY && !$past(AVS_WRITE) &&
    !$past(HW_STANDBY) |-> $stable(PB_OE_N))
    else $error("software standby moved enables");
  chk_reset_idle: assert property ($fell(RST) |-> PB_OE_N == 8'hFF &&
    PB_OUT == 8'h00) else $error("pins not idle after reset");
endmodule : pbp_chk

bind pbp_top pbp_chk chk_u (.REF_CLK, .RST, .AVS_ADDRESS, .AVS_READ,
  .AVS_WRITE, .AVS_WRITEDATA, .AVS_BYTEENABLE, .AVS_READDATA,
  .AVS_WAITREQUEST, .HW_STANDBY, .SW_STANDBY, .PB_OUT, .PB_OE_N,
  .CH4_CAP_A, .CH4_CAP_B, .CONVERTER_TRIGGER_IN_N);

// ### bench/pbp_board.sv
// Board model: resolves port B lines from both drivers
module pbp_board (
  input  logic [7:0] pb_out,
  input  logic [7:0] pb_oe_n,
  input  logic [7:0] ext,
  output logic [7:0] pb_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // No pull-ups: a released line shows the board pattern ext, as the bench last set it
  assign pb_in = (pb_out & ~pb_oe_n) | (ext & pb_oe_n);
endmodule : pbp_board

// ### bench/pbp_top_bench.sv
// Self-checking bench for the port B block
`include "pbp_params.svh"
module pbp_top_bench import pbp_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [17:0] A_DIR = {`PBP_IDX_DIR, 2'b00};
  localparam logic [17:0] A_LAT = {`PBP_IDX_LATCH, 2'b00};
  localparam logic [17:0] A_CFG = {`PBP_IDX_CFG, 2'b00};
  logic        clk = 1'b0, rst = 1'b1, rd = 1'b0, wr = 1'b0;
  logic        hws = 1'b0, sws = 1'b0, wreq, cap_a, cap_b, trig_n;
  logic [17:0] adr = '0;
  logic [31:0] wd = '0, rdata, q, r;
  logic [3:0]  tmr = 4'h0, be = 4'hF;
  logic [7:0]  pb_in, pb_out, pb_oe_n, ext = 8'h00, d, l;
  int          fail_count = 0, check_count = 0, seed = 33;
  always #2 clk = ~clk;
  pbp_top dut_u (.REF_CLK(clk), .RST(rst), .AVS_ADDRESS(adr),
    .AVS_READ(rd), .AVS_WRITE(wr), .AVS_WRITEDATA(wd),
    .AVS_BYTEENABLE(be), .AVS_READDATA(rdata), .AVS_WAITREQUEST(wreq),
    .HW_STANDBY(hws), .SW_STANDBY(sws), .PB_IN(pb_in), .PB_OUT(pb_out),
    .PB_OE_N(pb_oe_n), .CH4_CMP_A(tmr[0]), .CH4_CMP_B(tmr[1]),
    .CH4_INV_A(tmr[2]), .CH4_INV_B(tmr[3]), .CH4_CAP_A(cap_a),
    .CH4_CAP_B(cap_b), .CONVERTER_TRIGGER_IN_N(trig_n));
  pbp_board brd_u (.pb_out(pb_out), .pb_oe_n(pb_oe_n), .ext(ext),
    .pb_in(pb_in));
  task summarize;
    $display("checks %0d mismatches %0d", check_count, fail_count);
    if (fail_count == 0 && check_count > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : summarize
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  // Holds the request until waitrequest is seen low at a rising edge
  task bus(input logic w, input logic [17:0] a, input logic [31:0] v);
    adr <= a;
    wd <= v;
    wr <= w;
    rd <= !w;
    do begin
      @(posedge clk);
    end while (wreq !== 1'b0);
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge clk);
  endtask : bus
  function logic [7:0] exp_rd(input logic [7:0] dd, ll, ee);
    return (dd & ll) | (~dd & ee);
  endfunction : exp_rd
  initial begin
    #20000;
    fail_count++;
    summarize();
  end
  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    bus(0, A_DIR, 0);
    chk(q, `PBP_DIR_READ);
    bus(1, A_DIR, 32'hFF);
    bus(0, A_LAT, 0);
    chk(q, 32'h0);
    $display("test reset values done");
    repeat (40) begin
      r = $random(seed);
      d = r[7:0];
      l = r[15:8];
      ext <= r[23:16];
      bus(1, A_DIR, 32'(d));
      bus(1, A_LAT, 32'(l));
      repeat (6) @(posedge clk);
      bus(0, A_LAT, 0);
      chk(q, 32'(exp_rd(d, l, ext)));
      chk(32'(pb_oe_n), 32'(d ^ 8'hFF));
      chk(32'(pb_out), 32'(l));
    end
    $display("test random port traffic done");
    tmr <= r[27:24];
    bus(1, A_CFG, 32'h35);
    chk(32'(pb_oe_n[5:3]), 32'h0);
    chk(32'(pb_out[5:3]), 32'(tmr[3:1]));
    bus(1, A_CFG, 32'h2004);
    chk(32'(pb_oe_n[3]), 32'h0);
    bus(1, A_DIR, 0);
    ext <= r[31:24];
    bus(1, A_CFG, 32'h4444);
    repeat (6) @(posedge clk);
    chk(32'(pb_oe_n[3]), 32'h1);
    chk(32'({cap_a, cap_b, trig_n}),
      32'({ext[2], ext[3], ext[7]}));
    bus(1, A_CFG, 32'h4446);
    chk(32'({cap_a, cap_b}), 32'h0);
    bus(0, A_CFG, 0);
    chk(q, 32'h4446);
    bus(1, A_CFG, 32'h000A);
    chk(32'({pb_oe_n[2], pb_out[2]}), 32'({1'b0, tmr[0]}));
    bus(1, A_CFG, 32'h0108);
    chk(32'({pb_oe_n[2], pb_out[2]}), 32'({1'b0, tmr[0]}));
    bus(1, A_CFG, 32'h0408);
    chk(32'(pb_oe_n[2]), 32'h1);
    $display("test timer sharing done");
    bus(1, A_CFG, 0);
    bus(1, A_DIR, 32'(d));
    sws <= 1'b1;
    repeat (8) @(posedge clk);
    chk(32'({pb_oe_n, pb_out}), 32'({~d, l}));
    sws <= 1'b0;
    hws <= 1'b1;
    @(posedge clk);
    hws <= 1'b0;
    @(posedge clk);
    chk(32'(pb_oe_n), 32'hFF);
    bus(1, A_DIR, 32'hFF);
    bus(0, A_LAT, 0);
    chk(q, 32'h0);
    be <= 4'hE;
    bus(1, A_LAT, 32'hA5);
    be <= 4'hF;
    bus(1, A_LAT | 18'h1, 32'h5A);
    bus(0, A_LAT, 0);
    chk(q, 32'h0);
    bus(0, 18'h3FF64, 0);
    chk(q, 32'h0);
    $display("test standby and unmapped done");
    summarize();
  end
endmodule : pbp_top_bench
